// *** pkg/idmm_defs.vh ***
// Purpose: constants for the internal data memory map block
// Assumes: included by bare name from logic files
// Notes: addresses are core-side byte or bit addresses
`ifndef IDMM_DEFS_VH
`define IDMM_DEFS_VH
`define IDMM_OPC_NOP 8'h00
`define IDMM_NOP_BASE 16'hF800
`define IDMM_CODE_LAST 16'hF7FF
`define IDMM_LOWER_TOP 8'h7F
`define IDMM_BITRAM_BASE 8'h20
`define IDMM_BITRAM_LAST 8'h2F
`define IDMM_SFR_SPL 8'h81
`define IDMM_SFR_SPH 8'hB7
`define IDMM_SFR_CFG 8'hAF
`define IDMM_CFG_XSTK_BIT 7
`define IDMM_SPL_RESET 8'h07
`define IDMM_SPH_RESET 3'h0
`define IDMM_CFG_RESET 8'h00
`define IDMM_XSTK_BASE 11'h100
`define IDMM_ONCHIP_EXTENDED_RAM_BYTES 2048
`define IDMM_XSTK_BYTES 1792
`endif

// *** logic/idmm_ram.v ***
// Purpose: byte-wide flip-flop storage, one read and one write port
// Assumes: synchronous write, combinational read
// Notes: used for both internal ram and extended ram
`timescale 1ns/1ps
module idmm_ram #(
  parameter AW = 8,
  parameter DEPTH = 256
)(
  input wire clk,
  input wire ce,
  input wire we,
  input wire [AW-1:0] waddr,
  input wire [7:0] wdata,
  input wire [AW-1:0] raddr,
  output wire [7:0] rdata
);
  reg [7:0] mem [0:DEPTH-1];
  always @(posedge clk)
  begin
    if (ce && we)
    begin
      mem[waddr] <= wdata;
    end
  end
  assign rdata = mem[raddr];
endmodule

// *** logic/idmm_core.v ***
// Purpose: internal data memory map, code nop region and stack pointer
// Assumes: one core request per cycle; answers registered one cycle later
// Notes: bit access reads-modifies-writes the whole byte in one cycle
//
// How it works
// - fetches from F800H to FFFFH return the no-operation opcode
// - code fetches never leave the chip past F7FFH
// - lower 128 ram bytes reachable by direct and indirect forms
// - upper 128 bytes indirect only; direct there selects registers
// - lowest 32 bytes are four banks of eight working registers
// - bytes 20H-2FH also hold bit addresses 00H-7FH
// - reset sets pointer to 07H; push increments before writing
// - extended stacking off: 8-bit pointer wraps FFH to 00H
// - configuration bit 7 enables 11-bit pointer with three high bits
// - extended pointer continues past FFH at extended ram 0100H
// - extended ram holds 2048 bytes, 1792 usable as stack
// - low pointer byte at 81H, high three bits at B7H
// - unimplemented register reads return an undefined value
// - registers with low nibble 0H or 8H allow single-bit access
`timescale 1ns/1ps
`include "idmm_defs.vh"
module idmm_core #(
  parameter ONCHIP_EXTENDED_RAM_BYTES = `IDMM_ONCHIP_EXTENDED_RAM_BYTES
)(
  input wire clk,
  input wire rst_n,
  input wire ce,
  input wire [15:0] code_addr,
  input wire [7:0] code_flash_data,
  output reg [7:0] code_data,
  input wire acc_req,
  input wire acc_we,
  input wire acc_indirect,
  input wire acc_bit,
  input wire [7:0] acc_addr,
  input wire [7:0] acc_wdata,
  input wire acc_bit_val,
  input wire push_req,
  input wire pop_req,
  input wire [7:0] stack_wdata,
  input wire [7:0] sfr_ext_rdata,
  output reg [7:0] acc_rdata,
  output reg acc_bit_rdata,
  output reg sfr_ext_we,
  output reg [7:0] sfr_ext_addr,
  output reg [7:0] sfr_ext_wdata,
  output reg [10:0] stack_pointer,
  output reg ext_stack_en,
  output reg [1:0] bank_sel_unused
);
  // ****************************************
  // decode helpers
  // ****************************************
  function is_bitsfr;
    input [7:0] a;
    begin
      is_bitsfr = (a[2:0] == 3'h0);
    end
  endfunction

  // bit address to byte address
  function [7:0] bit_byte;
    input [7:0] b;
    begin
      if (b[7])
        bit_byte = {b[7:3], 3'h0};
      else
        bit_byte = `IDMM_BITRAM_BASE + {4'h0, b[6:3]};
    end
  endfunction

  // ****************************************
  // registers
  // ****************************************
  reg [7:0] stack_pointer_low;
  reg [2:0] stack_pointer_high;
  reg [7:0] chip_configuration_register;
  wire xstk = chip_configuration_register[`IDMM_CFG_XSTK_BIT];

  wire [10:0] sp_now = {stack_pointer_high, stack_pointer_low};
  wire [10:0] sp_inc = xstk ? sp_now + 11'h001 : {3'h0, stack_pointer_low + 8'h01};
  wire [10:0] sp_dec = xstk ? sp_now - 11'h001 : {3'h0, stack_pointer_low - 8'h01};

  // ****************************************
  // address resolution
  // ****************************************
  wire [7:0] byte_addr = acc_bit ? bit_byte(acc_addr) : acc_addr;
  // direct upper half goes to register space, indirect to ram
  wire to_sfr = !acc_indirect && byte_addr[7];
  wire [2:0] bitpos = acc_addr[2:0];

  wire [7:0] iram_rdata;
  wire [7:0] onchip_extended_ram_rdata;
  reg [7:0] sfr_rdata;
  reg sfr_hit;

  // ****************************************
  // stack address and storage ports
  // ****************************************
  // with extended stacking on, pointer above FFH selects extended ram; 0100H is first extended byte
  wire [10:0] push_addr = sp_inc;
  wire push_x = xstk && (push_addr >= `IDMM_XSTK_BASE);
  wire pop_x = xstk && (sp_now >= `IDMM_XSTK_BASE);
  wire [7:0] iram_raddr = pop_req ? sp_now[7:0] : byte_addr;

  reg [7:0] old_byte;
  reg [7:0] wr_byte;
  reg iram_we;
  reg onchip_extended_ram_we;
  reg [7:0] iram_waddr;
  always @*
  begin
    old_byte = to_sfr ? sfr_rdata : iram_rdata;
    wr_byte = acc_wdata;
    if (acc_bit)
    begin
      wr_byte = old_byte;
      wr_byte[bitpos] = acc_bit_val;
    end
    iram_we = 1'b0;
    onchip_extended_ram_we = 1'b0;
    iram_waddr = byte_addr;
    if (push_req)
    begin
      iram_we = !push_x;
      onchip_extended_ram_we = push_x;
      iram_waddr = push_addr[7:0];
    end
    else if (acc_req && acc_we && !to_sfr)
    begin
      iram_we = 1'b1;
    end
  end
  wire [7:0] iram_wdata = push_req ? stack_wdata : wr_byte;

  idmm_ram #(.AW(8), .DEPTH(256)) u_iram (
    .clk(clk),
    .ce(ce),
    .we(iram_we),
    .waddr(iram_waddr),
    .wdata(iram_wdata),
    .raddr(iram_raddr),
    .rdata(iram_rdata)
  );

  // extended ram, full size; stack uses 0100H upward
  idmm_ram #(.AW(11), .DEPTH(ONCHIP_EXTENDED_RAM_BYTES)) u_onchip_extended_ram (
    .clk(clk),
    .ce(ce),
    .we(onchip_extended_ram_we),
    .waddr(push_addr),
    .wdata(stack_wdata),
    .raddr(sp_now),
    .rdata(onchip_extended_ram_rdata)
  );

  // ****************************************
  // register space read
  // ****************************************
  always @*
  begin
    sfr_hit = 1'b1;
    case (byte_addr)
      `IDMM_SFR_SPL: sfr_rdata = stack_pointer_low;
      `IDMM_SFR_SPH: sfr_rdata = {5'h00, stack_pointer_high};
      `IDMM_SFR_CFG: sfr_rdata = chip_configuration_register;
      default:
      begin
        // unimplemented slots: value left to peripherals, undefined
        sfr_hit = 1'b0;
        sfr_rdata = sfr_ext_rdata;
      end
    endcase
  end

  // ****************************************
  // sequential state
  // ****************************************
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      stack_pointer_low <= `IDMM_SPL_RESET;
      stack_pointer_high <= `IDMM_SPH_RESET;
      chip_configuration_register <= `IDMM_CFG_RESET;
      code_data <= `IDMM_OPC_NOP;
      acc_rdata <= 8'h00;
      acc_bit_rdata <= 1'b0;
      sfr_ext_we <= 1'b0;
      sfr_ext_addr <= 8'h00;
      sfr_ext_wdata <= 8'h00;
      stack_pointer <= {3'h0, `IDMM_SPL_RESET};
      ext_stack_en <= 1'b0;
      bank_sel_unused <= 2'h0;
    end
    else if (ce)
    begin
      // no external code bus exists; top region reads as nop
      if (code_addr >= `IDMM_NOP_BASE)
        code_data <= `IDMM_OPC_NOP;
      else
        code_data <= code_flash_data;
      sfr_ext_we <= 1'b0;
      if (push_req)
      begin
        stack_pointer_low <= sp_inc[7:0];
        stack_pointer_high <= sp_inc[10:8];
      end
      else if (pop_req)
      begin
        acc_rdata <= pop_x ? onchip_extended_ram_rdata : iram_rdata;
        stack_pointer_low <= sp_dec[7:0];
        stack_pointer_high <= sp_dec[10:8];
      end
      else if (acc_req)
      begin
        acc_rdata <= old_byte;
        acc_bit_rdata <= old_byte[bitpos];
        if (acc_we && to_sfr)
        begin
          case (byte_addr)
            `IDMM_SFR_SPL: stack_pointer_low <= wr_byte;
            `IDMM_SFR_SPH: stack_pointer_high <= wr_byte[2:0];
            `IDMM_SFR_CFG: chip_configuration_register <= wr_byte;
            default:
            begin
              sfr_ext_we <= !sfr_hit;
              sfr_ext_addr <= byte_addr;
              sfr_ext_wdata <= wr_byte;
            end
          endcase
        end
      end
      stack_pointer <= sp_now;
      ext_stack_en <= xstk;
      bank_sel_unused <= 2'h0;
    end
  end
endmodule

// *** verification/idmm_core_assertions.sv ***
// Purpose: port checks for the memory map block
// Assumes: bound to idmm_core
// Notes: stack checks skip the cycle after a stack op
`timescale 1ns/1ps
module idmm_chk(
  input wire clk,
  input wire rst_n,
  input wire ce,
  input wire [15:0] code_addr,
  input wire [7:0] code_data,
  input wire acc_req,
  input wire acc_we,
  input wire acc_indirect,
  input wire acc_bit,
  input wire [7:0] acc_addr,
  input wire [7:0] acc_wdata,
  input wire push_req,
  input wire pop_req,
  input wire [7:0] acc_rdata,
  input wire sfr_ext_we,
  input wire [7:0] sfr_ext_addr,
  input wire [10:0] stack_pointer,
  input wire ext_stack_en
);
  // ****
  // properties
  // ****
  reg calm;
  wire a = ce & acc_req & !push_req & !pop_req;
  wire dr = a & !acc_we & !acc_indirect & !acc_bit;
  wire dw = a & acc_we & !acc_indirect & !acc_bit;
  wire pu = ce & push_req & calm;
  wire po = ce & pop_req & !push_req & calm;
  // pointer copy may lag a stack op by a cycle
  always @(posedge clk) calm <= !(push_req | pop_req);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  nop_fetch_a: assert property (ce && code_addr >= 16'hF800 |=> code_data == 8'h00)
    else $error("fetch not nop");
  sp_reset_a: assert property ($rose(rst_n) |-> stack_pointer == 11'h007)
    else $error("pointer reset");
  // the pointer copy shows the new value two edges after the stack op
  push_short_a: assert property (pu && !ext_stack_en |-> ##2
    stack_pointer == {$past(stack_pointer[10:8], 2), $past(stack_pointer[7:0], 2) + 8'h01})
    else $error("short push");
  push_long_a: assert property (pu && ext_stack_en |-> ##2
    stack_pointer == $past(stack_pointer, 2) + 11'h001) else $error("long push");
  pop_long_a: assert property (po && ext_stack_en |-> ##2
    stack_pointer == $past(stack_pointer, 2) - 11'h001) else $error("long pop");
  sp_low_a: assert property (dr && acc_addr == 8'h81 && calm |=>
    acc_rdata == stack_pointer[7:0]) else $error("pointer low read");
  cfg_bit_a: assert property (dw && acc_addr == 8'hAF |-> ##2
    ext_stack_en == $past(acc_wdata[7], 2)) else $error("config bit");
  sfr_fwd_a: assert property (dw && acc_addr[7] && acc_addr != 8'h81 && acc_addr != 8'hB7
    && acc_addr != 8'hAF |=> sfr_ext_we && sfr_ext_addr == $past(acc_addr))
    else $error("register write");
  cover property (pu && ext_stack_en);
  cover property (ce && code_addr >= 16'hF800);
  cover property (dw && acc_addr == 8'hAF);
endmodule
bind idmm_core idmm_chk i_chk(.*);

// *** verification/idmm_cpu_bfm.sv ***
// Purpose: core side model issuing access and stack requests
// Assumes: answer is read 1 ns after the taking edge
// Notes: data lines inverted once released
`timescale 1ns/1ps
module idmm_cpu_bfm(
  input wire clk,
  output reg acc_req,
  output reg acc_we,
  output reg acc_indirect,
  output reg acc_bit,
  output reg [7:0] acc_addr,
  output reg [7:0] acc_wdata,
  output reg acc_bit_val,
  output reg push_req,
  output reg pop_req,
  output reg [7:0] stack_wdata
);
  // ****
  // request tasks
  // ****
  initial {acc_req, acc_we, acc_indirect, acc_bit, acc_bit_val, push_req, pop_req} = 7'h00;
  initial {acc_addr, acc_wdata, stack_wdata} = 24'h000000;
  task fin;
    begin
      @(posedge clk);
      #1;
      {acc_req, push_req, pop_req} = 3'h0;
      acc_wdata = ~acc_wdata;
      stack_wdata = ~stack_wdata;
    end
  endtask
  task acc(input we, input ind, input bt, input [7:0] ad, input [7:0] d);
    begin
      @(posedge clk);
      #1;
      {acc_req, acc_we, acc_indirect, acc_bit} = {1'b1, we, ind, bt};
      acc_addr = ad;
      acc_wdata = d;
      acc_bit_val = d[0];
      fin;
    end
  endtask
  task stk(input pu, input [7:0] d);
    begin
      @(posedge clk);
      #1;
      {push_req, pop_req} = {pu, !pu};
      stack_wdata = d;
      fin;
    end
  endtask
endmodule

// *** verification/tb.sv ***
// Purpose: self-checking bench for the memory map block
// Assumes: core model drives all requests
// Notes: access answers read one cycle after the request; pop data and pointer copy read two cycles after
`timescale 1ns/1ps
module tb;
  reg clk = 1'b0;
  reg rst_n = 1'b0;
  reg [15:0] code_addr = 16'h0000;
  reg [7:0] code_flash_data = 8'h3C;
  integer err_total = 0;
  integer checks = 0;
  wire acc_req, acc_we, acc_indirect, acc_bit, acc_bit_val, push_req, pop_req;
  wire sfr_ext_we, ext_stack_en, acc_bit_rdata;
  wire [7:0] acc_addr, acc_wdata, stack_wdata, code_data, acc_rdata, sfr_ext_addr;
  wire [10:0] stack_pointer;
  always #12.5 clk = ~clk;
  idmm_cpu_bfm i_cpu(.*);
  idmm_core i_dut(.*, .ce(1'b1), .sfr_ext_rdata(8'h5A), .sfr_ext_wdata(), .bank_sel_unused());
  // ****
  // helpers
  // ****
  task chk(input [10:0] got, input [10:0] exp);
    begin
      checks = checks + 1;
      if (got !== exp)
      begin
        err_total = err_total + 1;
        $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task fetch(input [15:0] ad, input [7:0] e);
    begin
      code_addr = ad;
      @(posedge clk);
      #1;
      chk(code_data, e);
    end
  endtask
  // pointer copy and config copy trail the register by one edge
  task nxt;
    begin
      @(posedge clk);
      #1;
    end
  endtask
  task wr(input ind, input [7:0] ad, input [7:0] d);
    i_cpu.acc(1'b1, ind, 1'b0, ad, d);
  endtask
  task rd(input ind, input [7:0] ad, input [7:0] e);
    begin
      i_cpu.acc(1'b0, ind, 1'b0, ad, 8'h00);
      chk(acc_rdata, e);
    end
  endtask
  task conclude;
    begin
      $display("checks %0d errors %0d", checks, err_total);
      if (err_total == 0 && checks > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask
  initial
  begin
    repeat (20) @(posedge clk);
    #1;
    rst_n = 1'b1;
    chk(stack_pointer, 11'h007);
    rd(1'b0, 8'h81, 8'h07);
    fetch(16'hF7FF, 8'h3C);
    fetch(16'hF800, 8'h00);
    fetch(16'hFFFF, 8'h00);
    wr(1'b0, 8'h7F, 8'h11);
    rd(1'b1, 8'h7F, 8'h11);
    wr(1'b1, 8'h81, 8'hC3);
    rd(1'b1, 8'h81, 8'hC3);
    rd(1'b0, 8'h81, 8'h07);
    wr(1'b0, 8'h90, 8'h66);
    chk({sfr_ext_we, sfr_ext_addr}, 9'h190);
    i_cpu.stk(1'b1, 8'hAA);
    nxt;
    chk(stack_pointer, 11'h008);
    rd(1'b0, 8'h08, 8'hAA);
    i_cpu.stk(1'b0, 8'h00);
    nxt;
    chk({stack_pointer, acc_rdata}, 19'h007AA);
    wr(1'b0, 8'h21, 8'h00);
    i_cpu.acc(1'b1, 1'b0, 1'b1, 8'h0A, 8'h01);
    rd(1'b0, 8'h21, 8'h04);
    i_cpu.acc(1'b0, 1'b0, 1'b1, 8'h0A, 8'h00);
    chk(acc_bit_rdata, 1'b1);
    wr(1'b0, 8'h81, 8'hFF);
    i_cpu.stk(1'b1, 8'h5A);
    nxt;
    chk(stack_pointer, 11'h000);
    rd(1'b1, 8'h00, 8'h5A);
    wr(1'b0, 8'hAF, 8'h80);
    nxt;
    chk(ext_stack_en, 1'b1);
    wr(1'b0, 8'h81, 8'hFF);
    i_cpu.stk(1'b1, 8'hC4);
    nxt;
    chk(stack_pointer, 11'h100);
    i_cpu.acc(1'b0, 1'b0, 1'b0, 8'hB7, 8'h00);
    chk(acc_rdata[2:0], 3'h1);
    i_cpu.stk(1'b0, 8'h00);
    nxt;
    chk({stack_pointer, acc_rdata}, 19'h0FFC4);
    conclude;
  end
endmodule
